// File: common/crm_pkg.sv
// Purpose: Shared constants and types for the core register model.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes:   Special-function addresses and bus offsets are named here only.
package crm_pkg;

  // ----------------------------------------------------------------
  // Scratchpad layout
  // ----------------------------------------------------------------
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] DIRECT_LIMIT = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] DATA_POINTER_ZERO_RESET = 16'h0000;
  localparam logic [7:0] DPS_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] B_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Special-function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DP0L = 8'h82;
  localparam logic [7:0] SFR_DP0H = 8'h83;
  localparam logic [7:0] SFR_DP1L = 8'h84;
  localparam logic [7:0] SFR_DP1H = 8'h85;
  localparam logic [7:0] SFR_DPS = 8'h86;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_B = 8'hF0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_PAR = 0;
  localparam int PSW_BANK_LO = 3;
  localparam int DPS_SEL = 0;
  localparam int DPS_STEP = 3;
  localparam int DPS_DOWN = 4;
  localparam int DPS_TOGGLE = 5;
  localparam logic [7:0] DPS_MASK = 8'h39;

  // ----------------------------------------------------------------
  // Bus offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] A_ACC = 12'h000;
  localparam logic [11:0] A_B = 12'h004;
  localparam logic [11:0] A_PSW = 12'h008;
  localparam logic [11:0] A_SP = 12'h00C;
  localparam logic [11:0] A_DPS = 12'h010;
  localparam logic [11:0] A_DP0L = 12'h014;
  localparam logic [11:0] A_DP0H = 12'h018;
  localparam logic [11:0] A_DP1L = 12'h01C;
  localparam logic [11:0] A_DP1H = 12'h020;
  localparam logic [11:0] A_PC = 12'h024;
  localparam logic [1:0] A_RAM_PAGE = 2'b01;

  // ----------------------------------------------------------------
  // Core command types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CRM_NOP, CRM_DIR_RD, CRM_DIR_WR, CRM_IND_RD, CRM_IND_WR, CRM_REG_RD, CRM_REG_WR,
    CRM_BIT_RD, CRM_BIT_WR, CRM_PUSH, CRM_POP, CRM_CALL, CRM_RET, CRM_ALU, CRM_EXTERNAL_DATA_MOVE,
    CRM_DATA_POINTER_ZERO_LD, CRM_JUMP
  } crm_op_t;

  typedef struct packed {
    logic valid;
    crm_op_t op;
    logic [7:0] addr;
    logic [7:0] data;
    logic [15:0] wide;
    logic alu_cy;
    logic alu_ac;
    logic alu_ov;
    logic alu_wr_b;
    logic inc_pc;
  } crm_cmd_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } crm_wr_t;

endpackage

// File: hdl/crm_core_regs.sv
// Purpose: Programmer-visible registers and scratchpad of the core.
// Assumes: CMD comes from decode logic on CLK; APB master on CLK.
// Notes:   Core commands take priority; APB waits while CMD is valid.
`timescale 1ns/1ps
module crm_core_regs (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input crm_pkg::crm_cmd_t CMD,
  output logic [7:0] CMD_RDATA,
  output logic CMD_DONE,
  output logic [7:0] ACCUMULATOR_REGISTER,
  output logic [7:0] OPERAND_B,
  output logic [7:0] FLAG_WORD,
  output logic [7:0] STACK_TOP_POINTER,
  output logic [15:0] PROGRAM_COUNTER,
  output logic [15:0] XDATA_ADDR,
  output logic XDATA_STROBE
);
  import crm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic apb_go;
  logic apb_ram;
  logic apb_pc;
  logic apb_hit;
  logic [7:0] apb_sfr;
  logic [31:0] apb_rd;
  logic is_sfr;
  logic is_bit;
  logic alu_go;
  logic [1:0] bank;
  logic [7:0] ptr_reg_addr;
  logic [7:0] reg_addr;
  logic [7:0] bit_byte;
  logic [7:0] bit_src;
  logic [7:0] bit_new;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_rd;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] ram_a;
  logic [7:0] ram_b;
  logic [7:0] next_acc;
  crm_wr_t ram_wr;
  crm_wr_t ram_wr_hi;
  crm_wr_t sfr_wr;
  logic [7:0] pointer_select_register;
  logic [1:0][15:0] data_pointer_zero;
  logic [15:0] data_pointer_zero_active;

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  // Bank, pointer register, working register and bit byte addresses
  assign bank = FLAG_WORD[PSW_BANK_LO+1:PSW_BANK_LO];
  assign ptr_reg_addr = {3'b000, bank, 2'b00, CMD.addr[0]};
  assign reg_addr = {3'b000, bank, CMD.addr[2:0]};
  assign bit_byte = BIT_AREA_BASE + {4'h0, CMD.addr[6:3]};
  assign is_sfr = (CMD.addr >= DIRECT_LIMIT);
  assign is_bit = (CMD.op == CRM_BIT_RD) || (CMD.op == CRM_BIT_WR);
  assign alu_go = CMD.valid && (CMD.op == CRM_ALU);
  assign apb_go = PSEL && PENABLE && !PREADY && !CMD.valid;

  // Bus offset decode onto special-function addresses
  always_comb begin
    apb_sfr = 8'h00;
    apb_ram = 1'b0;
    apb_pc = 1'b0;
    apb_hit = 1'b1;
    if (PADDR[11:10] == A_RAM_PAGE && PADDR[1:0] == 2'b00) begin
      apb_ram = 1'b1;
    end else if (PADDR == A_ACC) begin
      apb_sfr = SFR_ACC;
    end else if (PADDR == A_B) begin
      apb_sfr = SFR_B;
    end else if (PADDR == A_PSW) begin
      apb_sfr = SFR_PSW;
    end else if (PADDR == A_SP) begin
      apb_sfr = SFR_SP;
    end else if (PADDR == A_DPS) begin
      apb_sfr = SFR_DPS;
    end else if (PADDR == A_DP0L) begin
      apb_sfr = SFR_DP0L;
    end else if (PADDR == A_DP0H) begin
      apb_sfr = SFR_DP0H;
    end else if (PADDR == A_DP1L) begin
      apb_sfr = SFR_DP1L;
    end else if (PADDR == A_DP1H) begin
      apb_sfr = SFR_DP1H;
    end else if (PADDR == A_PC) begin
      apb_pc = 1'b1;
    end else begin
      apb_hit = 1'b0;
    end
  end

  // Special-function byte select: bit ops use the byte holding the bit
  always_comb begin
    if (!CMD.valid) begin
      sfr_addr = apb_sfr;
    end else if (is_bit) begin
      sfr_addr = {CMD.addr[7:3], 3'b000};
    end else begin
      sfr_addr = CMD.addr;
    end
  end

  // Special-function read mux, unknown addresses read zero
  always_comb begin
    sfr_rd = 8'h00;
    if (sfr_addr == SFR_ACC) begin
      sfr_rd = ACCUMULATOR_REGISTER;
    end else if (sfr_addr == SFR_B) begin
      sfr_rd = OPERAND_B;
    end else if (sfr_addr == SFR_PSW) begin
      sfr_rd = FLAG_WORD;
    end else if (sfr_addr == SFR_SP) begin
      sfr_rd = STACK_TOP_POINTER;
    end else if (sfr_addr == SFR_DPS) begin
      sfr_rd = pointer_select_register;
    end else if (sfr_addr == SFR_DP0L) begin
      sfr_rd = data_pointer_zero[0][7:0];
    end else if (sfr_addr == SFR_DP0H) begin
      sfr_rd = data_pointer_zero[0][15:8];
    end else if (sfr_addr == SFR_DP1L) begin
      sfr_rd = data_pointer_zero[1][7:0];
    end else if (sfr_addr == SFR_DP1H) begin
      sfr_rd = data_pointer_zero[1][15:8];
    end
  end

  // ----------------------------------------------------------------
  // Scratchpad ports
  // ----------------------------------------------------------------
  // Read port A: data byte; port B: pointer register or return low
  always_comb begin
    rd_a = CMD.addr;
    if (!CMD.valid) begin
      rd_a = PADDR[9:2];
    end else begin
      case (CMD.op)
        CRM_IND_RD: rd_a = ram_b;
        CRM_REG_RD: rd_a = reg_addr;
        CRM_BIT_RD, CRM_BIT_WR: rd_a = bit_byte;
        CRM_POP, CRM_RET: rd_a = STACK_TOP_POINTER;
        default: rd_a = CMD.addr;
      endcase
    end
    rd_b = (CMD.op == CRM_RET) ? STACK_TOP_POINTER - 8'h01 : ptr_reg_addr;
  end

  // Bit read-modify-write on RAM or special-function byte
  always_comb begin
    bit_src = CMD.addr[7] ? sfr_rd : ram_a;
    bit_new = bit_src;
    bit_new[CMD.addr[2:0]] = CMD.data[0];
  end

  // Scratchpad write ports
  always_comb begin
    ram_wr = '0;
    ram_wr_hi = '0;
    if (CMD.valid) begin
      case (CMD.op)
        CRM_DIR_WR: if (!is_sfr) ram_wr = '{1'b1, CMD.addr, CMD.data};
        CRM_IND_WR: ram_wr = '{1'b1, ram_b, CMD.data};
        CRM_REG_WR: ram_wr = '{1'b1, reg_addr, CMD.data};
        CRM_BIT_WR: if (!CMD.addr[7]) ram_wr = '{1'b1, bit_byte, bit_new};
        CRM_PUSH: ram_wr = '{1'b1, STACK_TOP_POINTER + 8'h01, CMD.data};
        CRM_CALL: begin
          ram_wr = '{1'b1, STACK_TOP_POINTER + 8'h01, PROGRAM_COUNTER[7:0]};
          ram_wr_hi = '{1'b1, STACK_TOP_POINTER + 8'h02, PROGRAM_COUNTER[15:8]};
        end
        default: ram_wr = '0;
      endcase
    end else if (apb_go && PWRITE && apb_ram) begin
      ram_wr = '{1'b1, PADDR[9:2], PWDATA[7:0]};
    end
  end

  // Special-function write path shared by core and bus
  always_comb begin
    sfr_wr = '0;
    if (CMD.valid && CMD.op == CRM_DIR_WR && is_sfr) begin
      sfr_wr = '{1'b1, CMD.addr, CMD.data};
    end else if (CMD.valid && CMD.op == CRM_BIT_WR && CMD.addr[7]) begin
      sfr_wr = '{1'b1, sfr_addr, bit_new};
    end else if (apb_go && PWRITE && apb_sfr[7]) begin
      sfr_wr = '{1'b1, apb_sfr, PWDATA[7:0]};
    end
  end

  crm_scratch u_ram (
    .clk(CLK),
    .wr_a(ram_wr),
    .wr_b(ram_wr_hi),
    .rd_addr_a(rd_a),
    .rd_addr_b(rd_b),
    .rd_data_a(ram_a),
    .rd_data_b(ram_b)
  );

  crm_data_pointer_zero u_data_pointer_zero (
    .clk(CLK),
    .rst_n(RST_N),
    .sfr_wr(sfr_wr),
    .load_en(CMD.valid && CMD.op == CRM_DATA_POINTER_ZERO_LD),
    .load_val(CMD.wide),
    .use_en(CMD.valid && CMD.op == CRM_EXTERNAL_DATA_MOVE),
    .pointer_select_register(pointer_select_register),
    .ptr(data_pointer_zero),
    .active(data_pointer_zero_active)
  );

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Accumulator next value, shared with the parity flag
  always_comb begin
    next_acc = ACCUMULATOR_REGISTER;
    if (sfr_wr.en && sfr_wr.addr == SFR_ACC) begin
      next_acc = sfr_wr.data;
    end else if (alu_go) begin
      next_acc = CMD.data;
    end
  end

  // Accumulator and second operand
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ACCUMULATOR_REGISTER <= ACC_RESET;
      OPERAND_B <= B_RESET;
    end else begin
      ACCUMULATOR_REGISTER <= next_acc;
      if (sfr_wr.en && sfr_wr.addr == SFR_B) begin
        OPERAND_B <= sfr_wr.data;
      end else if (alu_go && CMD.alu_wr_b) begin
        OPERAND_B <= CMD.addr;
      end
    end
  end

  // Flag word; parity always tracks the accumulator
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FLAG_WORD <= PSW_RESET;
    end else begin
      if (sfr_wr.en && sfr_wr.addr == SFR_PSW) begin
        FLAG_WORD[7:1] <= sfr_wr.data[7:1];
      end else if (alu_go) begin
        FLAG_WORD[PSW_CY] <= CMD.alu_cy;
        FLAG_WORD[PSW_AC] <= CMD.alu_ac;
        FLAG_WORD[PSW_OV] <= CMD.alu_ov;
      end
      FLAG_WORD[PSW_PAR] <= ^next_acc;
    end
  end

  // Stack pointer
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      STACK_TOP_POINTER <= SP_RESET;
    end else if (sfr_wr.en && sfr_wr.addr == SFR_SP) begin
      STACK_TOP_POINTER <= sfr_wr.data;
    end else if (CMD.valid) begin
      case (CMD.op)
        CRM_PUSH: STACK_TOP_POINTER <= STACK_TOP_POINTER + 8'h01;
        CRM_POP: STACK_TOP_POINTER <= STACK_TOP_POINTER - 8'h01;
        CRM_CALL: STACK_TOP_POINTER <= STACK_TOP_POINTER + 8'h02;
        CRM_RET: STACK_TOP_POINTER <= STACK_TOP_POINTER - 8'h02;
        default: STACK_TOP_POINTER <= STACK_TOP_POINTER;
      endcase
    end
  end

  // Program counter: bus load, jump, call, return, else increment on a valid command with inc_pc
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PROGRAM_COUNTER <= PC_RESET;
    end else if (apb_go && PWRITE && apb_pc) begin
      PROGRAM_COUNTER <= PWDATA[15:0];
    end else if (CMD.valid && (CMD.op == CRM_JUMP || CMD.op == CRM_CALL)) begin
      PROGRAM_COUNTER <= CMD.wide;
    end else if (CMD.valid && CMD.op == CRM_RET) begin
      PROGRAM_COUNTER <= {ram_a, ram_b};
    end else if (CMD.valid && CMD.inc_pc) begin
      PROGRAM_COUNTER <= PROGRAM_COUNTER + 16'h0001;
    end
  end

  // External move address and strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      XDATA_ADDR <= DATA_POINTER_ZERO_RESET;
      XDATA_STROBE <= 1'b0;
    end else begin
      XDATA_STROBE <= CMD.valid && CMD.op == CRM_EXTERNAL_DATA_MOVE;
      if (CMD.valid && CMD.op == CRM_EXTERNAL_DATA_MOVE) begin
        XDATA_ADDR <= data_pointer_zero_active;
      end
    end
  end

  // Core read answers, one cycle after the command
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CMD_RDATA <= 8'h00;
      CMD_DONE <= 1'b0;
    end else begin
      CMD_DONE <= CMD.valid;
      if (CMD.valid && CMD.op == CRM_DIR_RD) begin
        CMD_RDATA <= is_sfr ? sfr_rd : ram_a;
      end else if (CMD.valid && CMD.op == CRM_BIT_RD) begin
        CMD_RDATA <= {7'h00, bit_src[CMD.addr[2:0]]};
      end else if (CMD.valid && CMD.op inside {CRM_IND_RD, CRM_REG_RD, CRM_POP}) begin
        CMD_RDATA <= ram_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave answer
  // ----------------------------------------------------------------
  assign apb_rd = apb_ram ? {24'h0000_00, ram_a} :
                  apb_pc ? {16'h0000, PROGRAM_COUNTER} : {24'h0000_00, sfr_rd};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_go;
      PSLVERR <= apb_go && !apb_hit;
      if (apb_go && !PWRITE) begin
        PRDATA <= apb_hit ? apb_rd : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sp_reset_a:
  assert property (@(posedge CLK) !RST_N |=> STACK_TOP_POINTER == SP_RESET)
    else $error("stack pointer wrong after reset");

  push_step_a:
  assert property (@(posedge CLK) disable iff (!RST_N) CMD.valid && CMD.op == CRM_PUSH
    |-> ram_wr.addr == STACK_TOP_POINTER + 8'h01 ##1 STACK_TOP_POINTER == $past(ram_wr.addr))
    else $error("push did not pre-increment");

  call_save_a:
  assert property (@(posedge CLK) disable iff (!RST_N) CMD.valid && CMD.op == CRM_CALL
    |=> STACK_TOP_POINTER == $past(STACK_TOP_POINTER) + 8'h02
        && PROGRAM_COUNTER == $past(CMD.wide))
    else $error("call did not save and branch");

  direct_sfr_a:
  assert property (@(posedge CLK) disable iff (!RST_N)
    CMD.valid && CMD.op == CRM_DIR_WR && CMD.addr[7] |-> !ram_wr.en && sfr_wr.en)
    else $error("direct upper write reached scratchpad");

  bank_reg_a:
  assert property (@(posedge CLK) disable iff (!RST_N) CMD.valid && CMD.op == CRM_REG_WR
    |-> ram_wr.addr[7:3] == {3'b000, FLAG_WORD[4:3]})
    else $error("working register outside selected bank");

  parity_a:
  assert property (@(posedge CLK) disable iff (!RST_N)
    FLAG_WORD[PSW_PAR] == ^ACCUMULATOR_REGISTER)
    else $error("parity flag does not match accumulator");

  alu_update_a:
  assert property (@(posedge CLK) disable iff (!RST_N) alu_go |=>
    FLAG_WORD[PSW_CY] == $past(CMD.alu_cy) && ACCUMULATOR_REGISTER == $past(CMD.data))
    else $error("arithmetic result or carry not stored");

  pc_step_a:
  assert property (@(posedge CLK) disable iff (!RST_N) CMD.valid && CMD.inc_pc
    && CMD.op inside {CRM_NOP, CRM_DIR_RD, CRM_PUSH} |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 16'h0001)
    else $error("program counter did not advance");

  external_data_move_addr_a:
  assert property (@(posedge CLK) disable iff (!RST_N) CMD.valid && CMD.op == CRM_EXTERNAL_DATA_MOVE
    |=> XDATA_STROBE && XDATA_ADDR == $past(data_pointer_zero[pointer_select_register[DPS_SEL]]))
    else $error("external move used wrong pointer");
endmodule

// File: hdl/crm_data_pointer_zero.sv
// Purpose: Two 16-bit data pointers with select, toggle and auto-step.
// Assumes: Pointer use is a one-cycle pulse from the move logic.
// Notes:   A byte write beats a load, a load beats a step.
`timescale 1ns/1ps
module crm_data_pointer_zero (
  input wire logic clk,
  input wire logic rst_n,
  input crm_pkg::crm_wr_t sfr_wr,
  input wire logic load_en,
  input wire logic [15:0] load_val,
  input wire logic use_en,
  output logic [7:0] pointer_select_register,
  output logic [1:0][15:0] ptr,
  output logic [15:0] active
);
  import crm_pkg::*;

  // Select register: write, else toggle after each pointer use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pointer_select_register <= DPS_RESET;
    end else if (sfr_wr.en && sfr_wr.addr == SFR_DPS) begin
      pointer_select_register <= sfr_wr.data & DPS_MASK;
    end else if (use_en && pointer_select_register[DPS_TOGGLE]) begin
      pointer_select_register[DPS_SEL] <= ~pointer_select_register[DPS_SEL];
    end
  end

  // Per-pointer byte writes, whole loads and stepping
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    localparam logic [7:0] LO = (i == 0) ? SFR_DP0L : SFR_DP1L;
    localparam logic [7:0] HI = (i == 0) ? SFR_DP0H : SFR_DP1H;
    logic mine;
    assign mine = (pointer_select_register[DPS_SEL] == 1'(i));
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ptr[i] <= DATA_POINTER_ZERO_RESET;
      end else if (sfr_wr.en && sfr_wr.addr == LO) begin
        ptr[i][7:0] <= sfr_wr.data;
      end else if (sfr_wr.en && sfr_wr.addr == HI) begin
        ptr[i][15:8] <= sfr_wr.data;
      end else if (load_en && mine) begin
        ptr[i] <= load_val;
      end else if (use_en && mine && pointer_select_register[DPS_STEP]) begin
        ptr[i] <= pointer_select_register[DPS_DOWN] ? ptr[i] - 16'h0001 : ptr[i] + 16'h0001;
      end
    end
  end

  // Active pointer follows the select bit
  assign active = ptr[pointer_select_register[DPS_SEL]];

  toggle_sel_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    use_en && pointer_select_register[DPS_TOGGLE] && !sfr_wr.en |=> pointer_select_register[DPS_SEL] != $past(pointer_select_register[DPS_SEL]))
    else $error("pointer select did not toggle after use");

  auto_step_a:
  assert property (@(posedge clk) disable iff (!rst_n)
    use_en && pointer_select_register[DPS_STEP] && !pointer_select_register[DPS_DOWN] && !sfr_wr.en && !load_en
    |=> $past(active) + 16'h0001 == ptr[$past(pointer_select_register[DPS_SEL])])
    else $error("active pointer did not step up");
endmodule

// File: hdl/crm_scratch.sv
// Purpose: 256-byte scratchpad storage, two write and two read ports.
// Assumes: Writers never hit the same byte in one cycle.
// Notes:   Reads are combinational; no reset on the storage.
`timescale 1ns/1ps
module crm_scratch (
  input wire logic clk,
  input crm_pkg::crm_wr_t wr_a,
  input crm_pkg::crm_wr_t wr_b,
  input wire logic [7:0] rd_addr_a,
  input wire logic [7:0] rd_addr_b,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b
);
  import crm_pkg::*;

  logic [7:0] mem [RAM_DEPTH];

  // Indexed byte writes, second port wins on a collision
  always_ff @(posedge clk) begin
    if (wr_a.en) begin
      mem[wr_a.addr] <= wr_a.data;
    end
    if (wr_b.en) begin
      mem[wr_b.addr] <= wr_b.data;
    end
  end

  // Asynchronous read ports
  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

  readback_a:
  assert property (@(posedge clk) wr_a.en && !(wr_b.en && wr_b.addr == wr_a.addr)
    ##1 rd_addr_a == $past(wr_a.addr) |-> rd_data_a == $past(wr_a.data))
    else $error("scratchpad byte lost its written value");
endmodule

// File: testbench/crm_decode_model.sv
// Purpose: Decode-side model that issues one core command per call.
// Assumes: Called from the bench; changes CMD just after a rising edge.
// Notes:   Valid stands for exactly one taking edge, then is released.
`timescale 1ns/1ps
module crm_decode_model (
  output crm_pkg::crm_cmd_t cmd,
  input wire logic clk
);
  import crm_pkg::*;
  initial cmd = '0;
  // Drive one command, release it after the taking edge, let outputs settle
  task automatic issue(input crm_op_t op, input logic [7:0] a, input logic [7:0] d,
                       input logic [15:0] w);
    @(posedge clk);
    // Every command asks for a counter step; loads of the counter win over it
    cmd <= '{valid: 1'b1, op: op, addr: a, data: d, wide: w, alu_cy: 1'b1,
             alu_ac: 1'b0, alu_ov: 1'b1, alu_wr_b: 1'b1, inc_pc: 1'b1};
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask
endmodule

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the core register model.
// Assumes: Decode model issues commands; the bench is the APB master.
// Notes:   Scratchpad bytes are written before they are read.
`timescale 1ns/1ps
module testbench;
  import crm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, xstb, done;
  logic [7:0] accum, opb, flags, stack_top, crd;
  logic [15:0] prog_cnt, xaddr;
  crm_cmd_t cmd;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // Clock and run limit
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end
  crm_decode_model crm_decode_model_i (.clk(clk), .cmd(cmd));
  crm_core_regs crm_core_regs_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CMD(cmd), .CMD_RDATA(crd), .CMD_DONE(done), .ACCUMULATOR_REGISTER(accum),
    .OPERAND_B(opb), .FLAG_WORD(flags), .STACK_TOP_POINTER(stack_top),
    .PROGRAM_COUNTER(prog_cnt), .XDATA_ADDR(xaddr), .XDATA_STROBE(xstb));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer, held until PREADY is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic c(input crm_op_t op, input logic [7:0] a, input logic [7:0] d,
                   input logic [15:0] w = 16'h0000);
    crm_decode_model_i.issue(op, a, d, w);
  endtask
  // Reset values, bus access and an unmapped offset
  task automatic t_bus;
    apb(1'b0, A_SP, 8'h00);
    chk("stack reset", {8'h00, SP_RESET}, rd[15:0]);
    chk("counter reset", PC_RESET, prog_cnt);
    apb(1'b1, A_ACC, 8'hA5);
    apb(1'b0, A_ACC, 8'h00);
    chk("accum", 16'h00A5, rd[15:0]);
    apb(1'b0, 12'h3F0, 8'h00);
    chk("unmapped", 16'h0001, {15'h0000, err});
  endtask
  // Push, pop, call and return through the stack
  task automatic t_stack;
    c(CRM_PUSH, 8'h00, 8'h3C);
    chk("push top", 16'h0008, {8'h00, stack_top});
    chk("push done", 16'h0001, {15'h0000, done});
    c(CRM_POP, 8'h00, 8'h00);
    chk("pop data", 16'h003C, {8'h00, crd});
    chk("pop top", 16'h0007, {8'h00, stack_top});
    chk("pc step", 16'h0002, prog_cnt);
    c(CRM_JUMP, 8'h00, 8'h00, 16'h1234);
    c(CRM_CALL, 8'h00, 8'h00, 16'h0040);
    chk("call target", 16'h0040, prog_cnt);
    chk("call top", 16'h0009, {8'h00, stack_top});
    apb(1'b0, 12'h420, 8'h00);
    chk("saved low", 16'h0034, rd[15:0]);
    c(CRM_RET, 8'h00, 8'h00);
    chk("return", 16'h1234, prog_cnt);
    apb(1'b1, A_SP, 8'hC0);
    c(CRM_PUSH, 8'h00, 8'h5E);
    apb(1'b0, 12'h704, 8'h00);
    chk("upper stack", 16'h005E, rd[15:0]);
  endtask
  // Indirect upper RAM, banks and the bit area
  task automatic t_ram;
    c(CRM_REG_WR, 8'h00, 8'h90);
    c(CRM_IND_WR, 8'h00, 8'h5A);
    c(CRM_DIR_RD, 8'h90, 8'h00);
    chk("direct upper", 16'h0000, {8'h00, crd});
    apb(1'b0, 12'h640, 8'h00);
    chk("ram 90", 16'h005A, rd[15:0]);
    c(CRM_IND_RD, 8'h00, 8'h00);
    chk("indirect", 16'h005A, {8'h00, crd});
    c(CRM_DIR_WR, SFR_PSW, 8'h18);
    c(CRM_REG_WR, 8'h07, 8'h66);
    c(CRM_DIR_RD, 8'h1F, 8'h00);
    chk("bank three", 16'h0066, {8'h00, crd});
    c(CRM_REG_RD, 8'h07, 8'h00);
    chk("reg read", 16'h0066, {8'h00, crd});
    c(CRM_DIR_WR, 8'h2F, 8'h00);
    c(CRM_BIT_WR, 8'h7F, 8'h01);
    c(CRM_DIR_RD, 8'h2F, 8'h00);
    chk("last bit", 16'h0080, {8'h00, crd});
    c(CRM_BIT_RD, 8'h7F, 8'h00);
    chk("bit read", 16'h0001, {8'h00, crd});
    c(CRM_BIT_WR, 8'hE1, 8'h01);
    chk("acc bit", 16'h00A7, {8'h00, accum});
  endtask
  // Pointer select, step and toggle on external moves
  task automatic t_ptr;
    c(CRM_DIR_WR, SFR_DPS, 8'h28);
    c(CRM_DATA_POINTER_ZERO_LD, 8'h00, 8'h00, 16'hFFFF);
    c(CRM_EXTERNAL_DATA_MOVE, 8'h00, 8'h00);
    chk("move addr", 16'hFFFF, xaddr);
    chk("move strobe", 16'h0001, {15'h0000, xstb});
    c(CRM_DIR_RD, SFR_DP0H, 8'h00);
    chk("step wrap", 16'h0000, {8'h00, crd});
    c(CRM_DIR_RD, SFR_DPS, 8'h00);
    chk("toggled", 16'h0029, {8'h00, crd});
    c(CRM_DATA_POINTER_ZERO_LD, 8'h00, 8'h00, 16'h2000);
    c(CRM_EXTERNAL_DATA_MOVE, 8'h00, 8'h00);
    chk("second ptr", 16'h2000, xaddr);
    c(CRM_DIR_RD, SFR_DP1L, 8'h00);
    chk("second step", 16'h0001, {8'h00, crd});
  endtask
  // Arithmetic result lands in operands and flags
  task automatic t_alu;
    c(CRM_ALU, 8'h44, 8'h33);
    chk("alu a", 16'h0033, {8'h00, accum});
    chk("alu b", 16'h0044, {8'h00, opb});
    chk("carry parity", 16'h0006, {13'h0000, flags[7], flags[2], flags[0]});
    apb(1'b1, A_PC, 8'h77);
    apb(1'b0, A_PC, 8'h00);
    chk("bus counter", 16'h0077, rd[15:0]);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_bus;
    t_stack;
    t_ram;
    t_ptr;
    t_alu;
    complete_run;
  end
endmodule
